// File: rtl/cpu_map_map.svh
// Offsets, field positions, reset values and address windows of the CPU status and map block.
// Included by the package only; design files see the macros through it. Definitions only.
`ifndef CPU_MAP_MAP_SVH
`define CPU_MAP_MAP_SVH
`define OFS_PTR_EXT 6'h0b
`define OFS_STATUS 6'h0f
`define RST_PTR_EXT 8'h00
`define RST_STATUS 8'h00
`define PTR_EXT_MASK 8'h01
`define BIT_IE 7
`define BIT_T 6
`define BIT_H 5
`define BIT_S 4
`define BIT_V 3
`define BIT_N 2
`define BIT_Z 1
`define BIT_C 0
`define IO_LO_END 16'h003f
`define IO_EXT_END 16'h103f
`define LOCK_BASE 16'h1040
`define LOCK_END 16'h104f
`define FUSE_BASE 16'h1050
`define FUSE_END 16'h105f
`define UROW_BASE 16'h1080
`define UROW_END 16'h109f
`define FROW_BASE 16'h1100
`define FROW_END 16'h117f
`define EE_BASE 16'h1400
`define EE_END 16'h15ff
`define SRAM_BASE 16'h4000
`define SRAM_END 16'h7fff
`define FWIN_BASE 16'h8000
`define PROG_TOP_LOW 17'h10000
`define PROG_TOP_WR 18'h20000
`define FLASH_PAGE_BITS 9
`define WAIT_CYCLES 2'h1
`endif

// File: rtl/cpu_map_pkg.sv
// Types for the CPU status and address map block.
// Assumes cpu_map_map.svh sits on the include path.
package cpu_map_pkg;
    `include "cpu_map_map.svh"

    typedef enum logic [7:0] {
        RG_NONE = 8'h00, RG_IO = 8'h01, RG_LOCK = 8'h02, RG_FUSE = 8'h04,
        RG_UROW = 8'h08, RG_FROW = 8'h10, RG_EE = 8'h20, RG_SRAM = 8'h40,
        RG_FLASH = 8'h80
    } region_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_DONE = 3'b100
    } io_state_e;

    typedef enum logic [3:0] {
        OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_PASS
    } alu_op_e;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] ptr_ext;
    } regs_s;

    typedef struct packed {
        logic [23:0] addr;
        region_e region;
        logic [16:0] flash_off;
        logic [7:0] page;
        logic fetch_ok;
    } decode_s;

    typedef struct packed {
        logic [7:0] res;
        logic c, z, n, v, h;
        logic h_valid, v_valid;
    } alu_flags_s;
endpackage

// File: rtl/flag_calc.sv
// Flag producer for arithmetic and logic results.
// Operands come from the sequencer on the same clock; purely combinational.
`timescale 1ns/1ns
module flag_calc
    import cpu_map_pkg::*;
(
    // Operation
    input wire alu_op_e op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    // Result
    output alu_flags_s fl
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic cbit;

    always_comb begin
        fl = '0;
        cbit = (op == OP_ADC || op == OP_SBC) ? cin : 1'b0;
        sum = 9'h000;
        nib = 5'h00;
        case (op)
            OP_ADD, OP_ADC: begin
                sum = {1'b0, a} + {1'b0, b} + {8'h00, cbit};
                nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cbit};
                fl.h_valid = 1'b1;
                fl.v_valid = 1'b1;
                fl.v = (a[7] == b[7]) && (sum[7] != a[7]);
            end
            OP_SUB, OP_SBC: begin
                sum = {1'b0, a} - {1'b0, b} - {8'h00, cbit};
                nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cbit};
                fl.h_valid = 1'b1;
                fl.v_valid = 1'b1;
                fl.v = (a[7] != b[7]) && (sum[7] != a[7]);
            end
            OP_AND: sum = {1'b0, a & b};
            OP_OR: sum = {1'b0, a | b};
            OP_XOR: sum = {1'b0, a ^ b};
            OP_PASS: sum = {1'b0, a};
            default: sum = 9'h000;
        endcase
        // Logic ops clear V, as usual for this family
        if (op inside {OP_AND, OP_OR, OP_XOR})
            fl.v_valid = 1'b1;
        fl.res = sum[7:0];
        fl.h = nib[4];
        fl.c = sum[8];
        fl.n = sum[7];
        fl.z = (sum[7:0] == 8'h00);
    end
endmodule

// File: rtl/addr_decode.sv
// Data-space and code-space address decoder.
// Pointer and extension come from registers on the same clock; combinational.
`timescale 1ns/1ns
module addr_decode
    import cpu_map_pkg::*;
(
    // Request
    input wire logic [7:0] ptr_ext,
    input wire logic [15:0] ptr,
    input wire logic use_ext,
    input wire logic code_space,
    // Decode
    output decode_s dec
);
    logic [15:0] a16;

    always_comb begin
        dec = '0;
        a16 = ptr;
        dec.addr = use_ext ? {ptr_ext, ptr} : {8'h00, ptr};
        if (code_space) begin
            dec.region = RG_FLASH;
            dec.flash_off = dec.addr[16:0];
            dec.fetch_ok = 1'b1;
        end else if (dec.addr[23:16] != 8'h00) begin
            dec.region = RG_NONE;
        end else if (a16 <= `IO_EXT_END) begin
            dec.region = RG_IO;
        end else if (a16 >= `LOCK_BASE && a16 <= `LOCK_END) begin
            dec.region = RG_LOCK;
        end else if (a16 >= `FUSE_BASE && a16 <= `FUSE_END) begin
            dec.region = RG_FUSE;
        end else if (a16 >= `UROW_BASE && a16 <= `UROW_END) begin
            dec.region = RG_UROW;
        end else if (a16 >= `FROW_BASE && a16 <= `FROW_END) begin
            dec.region = RG_FROW;
        end else if (a16 >= `EE_BASE && a16 <= `EE_END) begin
            dec.region = RG_EE;
        end else if (a16 >= `SRAM_BASE && a16 <= `SRAM_END) begin
            dec.region = RG_SRAM;
        end else if (a16 >= `FWIN_BASE) begin
            dec.region = RG_FLASH;
        end else begin
            dec.region = RG_NONE;
        end
        dec.page = dec.flash_off[16:`FLASH_PAGE_BITS];
    end
endmodule

// File: rtl/cpu_status_map.sv
// CPU status flags, pointer extension register, and data/code address routing.
// Sequencer and ALU drive the request ports on clk_sys; memories answer in the same cycle.
`timescale 1ns/1ns

// How it works
// - Global enable set lets interrupts through; clear blocks all regardless of peripherals.
// - Entering a handler or returning from one never changes the global enable.
// - Set-interrupt and clear-interrupt instructions set and clear the global enable.
// - Changing the global enable through an I/O write adds exactly one wait cycle.
// - T flag is written by bit-store and read by bit-load.
// - Half-carry from add and subtract set on carry out of low nibble, else cleared; other ops keep it.
// - Sign flag always equals negative xor overflow.
// - Overflow flag set on signed overflow, else cleared; OP_PASS and OP_NONE keep it.
// - Negative flag follows result bit seven.
// - Zero flag set when result is zero.
// - Carry flag set on carry out, else cleared.
// - Extended program reads and writes prepend the extension byte to the pointer.
// - Indirect data accesses prepend the extension byte when asked.
// - Extension forms the top byte; unimplemented bits read zero.
// - Data addresses 0x8000 to 0xffff reach a 32 KB flash window.
// - Program reads and writes reach all flash from address zero.
// - Flash is 16-bit words in 256 pages of 512 bytes.
// - Flash splits into boot, application code and data sections for write protection.
// - SRAM sits at 0x4000, 16 KB, holds stack, cannot be fetched from.
// - EEPROM sits at 0x1400, 512 bytes, byte and multibyte access.
// - I/O at 0x0000 to 0x003f, extended I/O up to 0x103f.
// - Lock, fuse, user row and factory row each have their fixed windows.
module cpu_status_map
    import cpu_map_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // I/O register port
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_wait,
    // Sequencer flag commands
    input wire logic irq_on_insn,
    input wire logic irq_off_insn,
    input wire logic irq_return_insn,
    input wire logic isr_enter,
    input wire logic bit_copy_out_insn,
    input wire logic bit_copy_in_insn,
    input wire logic [7:0] bit_src,
    input wire logic [2:0] bit_sel,
    output logic [7:0] bit_copy_result,
    // ALU result flags
    input wire logic alu_en,
    input wire alu_op_e alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    output logic [7:0] alu_res,
    // Interrupt gate
    input wire logic periph_irq,
    output logic irq_take,
    // Memory access request
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_fetch,
    input wire logic code_space,
    input wire logic use_ext,
    input wire logic [15:0] ptr,
    input wire logic [7:0] mem_wdata,
    input wire logic [1:0] cur_section,
    input wire logic [7:0] boot_pages,
    input wire logic [7:0] code_pages,
    output logic [23:0] mem_addr,
    output region_e mem_region,
    output logic [7:0] flash_page,
    output logic mem_we_out,
    output logic mem_fault,
    output logic [7:0] mem_rdata,
    // Memory read data by region
    input wire logic [7:0] io_bus_rdata,
    input wire logic [7:0] nvm_rdata,
    input wire logic [7:0] sram_rdata,
    input wire logic [7:0] flash_rdata
);
    typedef struct packed {
        regs_s regs;
        io_state_e st;
        logic [7:0] bit_out;
        logic [7:0] res;
        logic [7:0] rdata;
        logic [7:0] io_rd_d;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    alu_flags_s fl;
    decode_s dec;
    logic [1:0] tgt_section;
    logic wr_blocked;

    flag_calc u_flag (
        .op(alu_op),
        .a(alu_a),
        .b(alu_b),
        .cin(s_r.regs.flags[`BIT_C]),
        .fl(fl)
    );

    addr_decode u_dec (
        .ptr_ext(s_r.regs.ptr_ext),
        .ptr(ptr),
        .use_ext(use_ext),
        .code_space(code_space),
        .dec(dec)
    );

    // Section of target page: 0 boot, 1 application code, 2 application data
    always_comb begin
        if (dec.page < boot_pages)
            tgt_section = 2'd0;
        else if (dec.page < code_pages)
            tgt_section = 2'd1;
        else
            tgt_section = 2'd2;
    end

    // Code may only write its own section or a later one
    assign wr_blocked = code_space && mem_we && (tgt_section < cur_section);

    always_comb begin
        s_nxt = s_r;
        // I/O write of the status register; the wait state holds the access one cycle
        case (s_r.st)
            ST_IDLE: begin
                if (io_wr && io_addr == `OFS_STATUS &&
                    io_wdata[`BIT_IE] != s_r.regs.flags[`BIT_IE])
                    s_nxt.st = ST_WAIT;
                else if (io_wr && io_addr == `OFS_STATUS)
                    s_nxt.regs.flags = io_wdata;
            end
            ST_WAIT: begin
                s_nxt.regs.flags = io_wdata;
                s_nxt.st = ST_IDLE;
            end
            ST_DONE: s_nxt.st = ST_IDLE;
            default: s_nxt.st = ST_IDLE;
        endcase
        if (io_wr && io_addr == `OFS_PTR_EXT && s_r.st == ST_IDLE)
            s_nxt.regs.ptr_ext = io_wdata & `PTR_EXT_MASK;
        if (irq_on_insn)
            s_nxt.regs.flags[`BIT_IE] = 1'b1;
        if (irq_off_insn)
            s_nxt.regs.flags[`BIT_IE] = 1'b0;
        // Handler entry and return leave the enable untouched
        if (isr_enter || irq_return_insn)
            s_nxt.regs.flags[`BIT_IE] = s_nxt.regs.flags[`BIT_IE];
        if (bit_copy_out_insn)
            s_nxt.regs.flags[`BIT_T] = bit_src[bit_sel];
        s_nxt.bit_out = bit_src;
        if (bit_copy_in_insn)
            s_nxt.bit_out[bit_sel] = s_r.regs.flags[`BIT_T];
        if (alu_en) begin
            s_nxt.res = fl.res;
            s_nxt.regs.flags[`BIT_C] = fl.c;
            s_nxt.regs.flags[`BIT_Z] = fl.z;
            s_nxt.regs.flags[`BIT_N] = fl.n;
            if (fl.v_valid)
                s_nxt.regs.flags[`BIT_V] = fl.v;
            if (fl.h_valid)
                s_nxt.regs.flags[`BIT_H] = fl.h;
        end
        // Sign is re-derived after every update, so a direct write cannot break it
        s_nxt.regs.flags[`BIT_S] = s_nxt.regs.flags[`BIT_N] ^ s_nxt.regs.flags[`BIT_V];
        // I/O read data
        case (io_addr)
            `OFS_STATUS: s_nxt.io_rd_d = s_r.regs.flags;
            `OFS_PTR_EXT: s_nxt.io_rd_d = s_r.regs.ptr_ext;
            default: s_nxt.io_rd_d = 8'h00;
        endcase
        if (!io_rd)
            s_nxt.io_rd_d = 8'h00;
        // Memory read data steering
        s_nxt.rdata = 8'h00;
        if (mem_req && !mem_we) begin
            case (dec.region)
                RG_IO: s_nxt.rdata = io_bus_rdata;
                RG_LOCK, RG_FUSE, RG_UROW, RG_FROW, RG_EE: s_nxt.rdata = nvm_rdata;
                RG_SRAM: s_nxt.rdata = mem_fetch ? 8'h00 : sram_rdata;
                RG_FLASH: s_nxt.rdata = flash_rdata;
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r.regs.flags <= `RST_STATUS;
            s_r.regs.ptr_ext <= `RST_PTR_EXT;
            s_r.st <= ST_IDLE;
            s_r.bit_out <= 8'h00;
            s_r.res <= 8'h00;
            s_r.rdata <= 8'h00;
            s_r.io_rd_d <= 8'h00;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Gate for every peripheral request
    assign irq_take = periph_irq && s_r.regs.flags[`BIT_IE];
    // Only the detecting cycle stalls; the held write lands at the edge that ends the wait state
    assign io_wait = (s_r.st == ST_IDLE) ? (io_wr && io_addr == `OFS_STATUS &&
        io_wdata[`BIT_IE] != s_r.regs.flags[`BIT_IE]) : 1'b0;
    assign io_rdata = s_r.io_rd_d;
    assign bit_copy_result = s_r.bit_out;
    assign alu_res = s_r.res;
    assign mem_rdata = s_r.rdata;
    assign mem_addr = dec.addr;
    assign mem_region = dec.region;
    assign flash_page = dec.page;
    // Fetch from SRAM and writes to reserved space are refused
    assign mem_fault = mem_req && ((mem_fetch && dec.region != RG_FLASH) || wr_blocked);
    assign mem_we_out = mem_req && mem_we && dec.region != RG_NONE && !wr_blocked;

    default clocking prop_clk @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // Reference sums for the add checks, kept apart from the flag producer
    logic [8:0] ref_sum;
    logic [8:0] ref_ssum;
    logic [4:0] ref_nib;
    logic ref_cy;
    logic ref_hc;
    logic ref_ov;
    assign ref_sum = {1'b0, alu_a} + {1'b0, alu_b};
    assign ref_ssum = {alu_a[7], alu_a} + {alu_b[7], alu_b};
    assign ref_nib = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
    assign ref_cy = ref_sum[8];
    assign ref_hc = ref_nib[4];
    assign ref_ov = ref_ssum[8] != ref_ssum[7];

    sequence ie_io_change;
        s_r.st == ST_IDLE && io_wr && io_addr == `OFS_STATUS &&
            io_wdata[`BIT_IE] != s_r.regs.flags[`BIT_IE];
    endsequence

    sequence add_step;
        alu_en && alu_op == OP_ADD && !io_wr && s_r.st == ST_IDLE;
    endsequence

    a_sign_rel: assert property (
        s_r.regs.flags[`BIT_S] == (s_r.regs.flags[`BIT_N] ^ s_r.regs.flags[`BIT_V]))
        else $error("sign flag not n xor v");

    a_irq_gate: assert property (
        !s_r.regs.flags[`BIT_IE] |-> !irq_take)
        else $error("interrupt passed while disabled");

    a_ie_keep: assert property (
        (isr_enter || irq_return_insn) && !irq_on_insn && !irq_off_insn && !io_wr
        |=> $stable(s_r.regs.flags[`BIT_IE]))
        else $error("handler entry changed enable");

    a_sei_sets: assert property (
        irq_on_insn && !irq_off_insn && s_r.st == ST_IDLE && !io_wr
        |=> s_r.regs.flags[`BIT_IE])
        else $error("set-interrupt did not set enable");

    a_cli_clears: assert property (
        irq_off_insn |=> !s_r.regs.flags[`BIT_IE])
        else $error("clear-interrupt did not clear enable");

    a_wait_one: assert property (
        ie_io_change |-> io_wait ##1 !io_wait)
        else $error("enable write wait not one cycle");

    a_bst_copy: assert property (
        bit_copy_out_insn && !(io_wr && io_addr == `OFS_STATUS) && s_r.st == ST_IDLE
        |=> s_r.regs.flags[`BIT_T] == |(($past(bit_src) >> $past(bit_sel)) & 8'h01))
        else $error("bit store wrong");

    a_half_add: assert property (
        add_step |=> s_r.regs.flags[`BIT_H] == $past(ref_hc))
        else $error("half carry mismatch");

    a_ovf_add: assert property (
        add_step |=> s_r.regs.flags[`BIT_V] == $past(ref_ov))
        else $error("overflow flag mismatch");

    a_neg_flag: assert property (
        alu_en && !io_wr && s_r.st == ST_IDLE |=> s_r.regs.flags[`BIT_N] == alu_res[7])
        else $error("negative flag mismatch");

    a_zero_flag: assert property (
        alu_en && !io_wr && s_r.st == ST_IDLE |=> s_r.regs.flags[`BIT_Z] == (alu_res == 8'h00))
        else $error("zero flag mismatch");

    a_carry_add: assert property (
        add_step |=> s_r.regs.flags[`BIT_C] == $past(ref_cy))
        else $error("carry flag mismatch");

    a_ext_top: assert property (
        use_ext |-> mem_addr[23:16] == s_r.regs.ptr_ext && mem_addr[15:0] == ptr)
        else $error("extension byte not on top");

    a_ext_zero: assert property (
        (s_r.regs.ptr_ext & ~`PTR_EXT_MASK) == 8'h00)
        else $error("unimplemented extension bit set");

    a_win_flash: assert property (
        !code_space && !use_ext && ptr >= `FWIN_BASE |-> mem_region == RG_FLASH)
        else $error("flash window misdecoded");

    a_code_addr: assert property (
        code_space && !use_ext |-> mem_addr == {8'h00, ptr} && mem_region == RG_FLASH)
        else $error("code address not from zero");

    a_page_calc: assert property (
        code_space |-> flash_page == mem_addr[16:`FLASH_PAGE_BITS])
        else $error("flash page wrong");

    a_sram_map: assert property (
        !code_space && !use_ext && ptr >= `SRAM_BASE && ptr <= `SRAM_END
        |-> mem_region == RG_SRAM)
        else $error("sram misdecoded");

    a_sram_fetch: assert property (
        mem_req && mem_fetch && mem_region == RG_SRAM |-> mem_fault)
        else $error("fetch from sram not refused");

    a_ee_map: assert property (
        !code_space && !use_ext && ptr >= `EE_BASE && ptr <= `EE_END
        |-> mem_region == RG_EE)
        else $error("eeprom misdecoded");

    a_io_map: assert property (
        !code_space && !use_ext && ptr <= `IO_EXT_END |-> mem_region == RG_IO)
        else $error("io space misdecoded");

    a_gap_zero: assert property (
        mem_req && !mem_we && mem_region == RG_NONE |=> mem_rdata == 8'h00)
        else $error("reserved read nonzero");

    a_gap_nowr: assert property (
        mem_req && mem_region == RG_NONE |-> !mem_we_out)
        else $error("reserved write passed");
endmodule

// File: testbench/mem_responder.sv
// Memory model answering the read-data inputs of the status and map block.
// Assumes the block's one-hot region output selects which memory answers.
`timescale 1ns/1ns
module mem_responder
    import cpu_map_pkg::*;
#(
    parameter logic [7:0] IO_PAT = 8'h3c,
    parameter logic [7:0] NVM_PAT = 8'h5a,
    parameter logic [7:0] SRAM_PAT = 8'ha6,
    parameter logic [7:0] FLASH_PAT = 8'hc9
) (
    // Selection
    input wire region_e region,
    // Read data
    output logic [7:0] io_bus_rdata,
    output logic [7:0] nvm_rdata,
    output logic [7:0] sram_rdata,
    output logic [7:0] flash_rdata
);
    logic nvm_sel;

    // Unselected memories show the inverse, so a missing select cannot pass as zero
    assign nvm_sel = region inside {RG_LOCK, RG_FUSE, RG_UROW, RG_FROW, RG_EE};
    assign io_bus_rdata = (region == RG_IO) ? IO_PAT : ~IO_PAT;
    assign nvm_rdata = nvm_sel ? NVM_PAT : ~NVM_PAT;
    assign sram_rdata = (region == RG_SRAM) ? SRAM_PAT : ~SRAM_PAT;
    assign flash_rdata = (region == RG_FLASH) ? FLASH_PAT : ~FLASH_PAT;
endmodule

// File: testbench/cpu_status_and_address_map_tb.sv
// Self-checking bench for the CPU status flags, extension register and map.
// Assumes the design files and mem_responder are compiled first.
`timescale 1ns/1ns
module cpu_status_and_address_map_tb;
    import cpu_map_pkg::*;
    logic clk_sys = 0, rstn = 0;
    logic io_wr = 0, io_rd = 0, irq_on_insn = 0, irq_off_insn = 0, irq_return_insn = 0;
    logic isr_enter = 0, bit_copy_out_insn = 0, bit_copy_in_insn = 0, alu_en = 0;
    logic periph_irq = 0, mem_req = 0, mem_we = 0, code_space = 0, use_ext = 0;
    logic mem_fetch = 0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, bit_src = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
    logic [7:0] mem_wdata = 8'h00, boot_pages = 8'h08, code_pages = 8'h10;
    logic [2:0] bit_sel = 3'h0;
    logic [1:0] cur_section = 2'h2;
    logic [15:0] ptr = 16'h0000;
    alu_op_e alu_op = OP_NONE;
    logic [7:0] io_rdata, bit_copy_result, alu_res, flash_page, mem_rdata;
    logic [7:0] io_bus_rdata, nvm_rdata, sram_rdata, flash_rdata;
    logic io_wait, irq_take, mem_we_out, mem_fault;
    logic [23:0] mem_addr;
    region_e mem_region;
    int fails = 0, comparisons = 0;

    always #25 clk_sys = ~clk_sys;

    cpu_status_map dut_u (.clk_sys(clk_sys), .rstn(rstn), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_wait(io_wait),
        .irq_on_insn(irq_on_insn), .irq_off_insn(irq_off_insn),
        .irq_return_insn(irq_return_insn), .isr_enter(isr_enter),
        .bit_copy_out_insn(bit_copy_out_insn), .bit_copy_in_insn(bit_copy_in_insn),
        .bit_src(bit_src), .bit_sel(bit_sel), .bit_copy_result(bit_copy_result),
        .alu_en(alu_en), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_res(alu_res),
        .periph_irq(periph_irq), .irq_take(irq_take), .mem_req(mem_req), .mem_we(mem_we),
        .mem_fetch(mem_fetch), .code_space(code_space), .use_ext(use_ext), .ptr(ptr),
        .mem_wdata(mem_wdata), .cur_section(cur_section), .boot_pages(boot_pages),
        .code_pages(code_pages), .mem_addr(mem_addr), .mem_region(mem_region),
        .flash_page(flash_page), .mem_we_out(mem_we_out), .mem_fault(mem_fault),
        .mem_rdata(mem_rdata), .io_bus_rdata(io_bus_rdata), .nvm_rdata(nvm_rdata),
        .sram_rdata(sram_rdata), .flash_rdata(flash_rdata));

    mem_responder mem_u (.region(mem_region), .io_bus_rdata(io_bus_rdata),
        .nvm_rdata(nvm_rdata), .sram_rdata(sram_rdata), .flash_rdata(flash_rdata));

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until the edge after io_wait is seen low
    task automatic io_write(input logic [5:0] a, input logic [7:0] d, input int exp_wait);
        int n;
        logic w;
        n = 0;
        @(negedge clk_sys);
        io_wr = 1;
        io_addr = a;
        io_wdata = d;
        do begin
            #1 w = io_wait;
            if (w === 1'b1) n++;
            @(negedge clk_sys);
        end while (w === 1'b1 && n < 8);
        io_wr = 0;
        chk("io_wait cycles", 24'(exp_wait), 24'(n));
    endtask

    task automatic io_read(input logic [5:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(negedge clk_sys);
        io_rd = 1;
        io_addr = a;
        @(negedge clk_sys);
        io_rd = 0;
        chk("io_rdata", {16'h0, exp & m}, {16'h0, io_rdata & m});
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1;
        @(negedge clk_sys);
        s = 0;
    endtask

    task automatic alu(input alu_op_e op, input logic [7:0] a, input logic [7:0] b,
            input logic [7:0] res);
        @(negedge clk_sys);
        alu_en = 1;
        alu_op = op;
        alu_a = a;
        alu_b = b;
        @(negedge clk_sys);
        alu_en = 0;
        chk("alu_res", {16'h0, res}, {16'h0, alu_res});
    endtask

    task automatic t_enable();
        io_read(`OFS_STATUS, 8'h00, 8'hff);
        io_read(`OFS_PTR_EXT, 8'h00, 8'hff);
        periph_irq = 1;
        #1 chk("irq_take", 0, irq_take);
        io_write(`OFS_STATUS, 8'h80, 1);
        io_read(`OFS_STATUS, 8'h80, 8'hff);
        chk("irq_take", 1, irq_take);
        pulse(isr_enter);
        pulse(irq_return_insn);
        io_read(`OFS_STATUS, 8'h80, 8'hff);
        io_write(`OFS_STATUS, 8'h80, 0);
        pulse(irq_off_insn);
        #1 chk("irq_take", 0, irq_take);
        io_read(`OFS_STATUS, 8'h00, 8'hff);
        pulse(irq_on_insn);
        io_read(`OFS_STATUS, 8'h80, 8'hff);
    endtask

    task automatic t_bits_alu();
        bit_src = 8'h04;
        bit_sel = 3'h2;
        pulse(bit_copy_out_insn);
        io_read(`OFS_STATUS, 8'hc0, 8'hff);
        bit_src = 8'h00;
        bit_sel = 3'h5;
        pulse(bit_copy_in_insn);
        chk("bit_copy_result", 24'h20, {16'h0, bit_copy_result});
        alu(OP_ADD, 8'h0f, 8'h01, 8'h10);
        io_read(`OFS_STATUS, 8'he0, 8'hff);
        alu(OP_ADD, 8'h7f, 8'h01, 8'h80);
        io_read(`OFS_STATUS, 8'hec, 8'hff);
        alu(OP_ADD, 8'hff, 8'h01, 8'h00);
        io_read(`OFS_STATUS, 8'he3, 8'hff);
        alu(OP_SUB, 8'h00, 8'h01, 8'hff);
        io_read(`OFS_STATUS, 8'hf5, 8'hff);
        alu(OP_ADC, 8'h01, 8'h01, 8'h03);
        io_read(`OFS_STATUS, 8'hc0, 8'hff);
        alu(OP_AND, 8'h80, 8'hc0, 8'h80);
        // Carry after a logic op is left to the design; only S, V, N and Z are judged
        io_read(`OFS_STATUS, 8'h14, 8'h1e);
        alu(OP_OR, 8'h50, 8'h0a, 8'h5a);
        alu(OP_XOR, 8'h5a, 8'h5a, 8'h00);
        io_read(`OFS_STATUS, 8'h02, 8'h1e);
        alu(OP_SBC, 8'h10, 8'h01, 8'h0f);
        io_read(`OFS_STATUS, 8'he0, 8'hff);
    endtask

    task automatic t_decode();
        logic [15:0] p [12] = '{16'h0000, 16'h103f, 16'h1040, 16'h1050, 16'h1080, 16'h1100,
            16'h1400, 16'h15ff, 16'h1600, 16'h4000, 16'h7fff, 16'h8000};
        region_e r [12] = '{RG_IO, RG_IO, RG_LOCK, RG_FUSE, RG_UROW, RG_FROW, RG_EE, RG_EE,
            RG_NONE, RG_SRAM, RG_SRAM, RG_FLASH};
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_sys);
            ptr = p[i];
            #1 chk("mem_region", {16'h0, r[i]}, {16'h0, mem_region});
        end
    endtask

    task automatic mem_op(input logic we, input logic [15:0] p, input logic [7:0] exp);
        @(negedge clk_sys);
        mem_req = 1;
        mem_we = we;
        ptr = p;
        #1 if (we) chk("mem_we_out", {23'h0, p != 16'h1600}, {23'h0, mem_we_out});
        @(negedge clk_sys);
        mem_req = 0;
        mem_we = 0;
        if (!we) chk("mem_rdata", {16'h0, exp}, {16'h0, mem_rdata});
    endtask

    task automatic t_ext_code();
        io_write(`OFS_PTR_EXT, 8'hff, 0);
        io_read(`OFS_PTR_EXT, 8'h01, 8'hff);
        mem_op(0, 16'h4010, 8'ha6);
        mem_op(0, 16'h9000, 8'hc9);
        mem_op(0, 16'h1600, 8'h00);
        mem_op(1, 16'h1600, 8'h00);
        mem_op(1, 16'h4000, 8'h00);
        @(negedge clk_sys);
        mem_req = 1;
        mem_fetch = 1;
        ptr = 16'h4000;
        #1 chk("mem_fault", 1, {23'h0, mem_fault});
        @(negedge clk_sys);
        ptr = 16'h8000;
        #1 chk("mem_fault", 0, {23'h0, mem_fault});
        chk("mem_rdata", 24'h0, {16'h0, mem_rdata});
        @(negedge clk_sys);
        mem_req = 0;
        mem_fetch = 0;
        @(negedge clk_sys);
        use_ext = 1;
        ptr = 16'h1234;
        #1 chk("mem_addr", 24'h011234, mem_addr);
        @(negedge clk_sys);
        code_space = 1;
        use_ext = 0;
        mem_req = 1;
        mem_we = 1;
        ptr = 16'h0400;
        #1 chk("mem_addr", 24'h000400, mem_addr);
        chk("flash_page", 24'h2, {16'h0, flash_page});
        chk("mem_fault", 1, {23'h0, mem_fault});
        @(negedge clk_sys);
        use_ext = 1;
        ptr = 16'h0200;
        #1 chk("mem_addr", 24'h010200, mem_addr);
        chk("flash_page", 24'h81, {16'h0, flash_page});
        chk("mem_fault", 0, {23'h0, mem_fault});
        @(negedge clk_sys);
        mem_req = 0;
        mem_we = 0;
        code_space = 0;
        use_ext = 0;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole sequence needs well under 300 cycles
    initial begin
        #(50 * 3000);
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1;
        t_enable();
        t_bits_alu();
        t_decode();
        t_ext_code();
        report_and_stop();
    end
endmodule
